// ==== core/apw_defines.svh ====
// Offsets, fields, reset values and timing counts for the auto powerdown block.
// Assumes a 20 MHz mclk; included by name wherever the constants are used.
`ifndef APW_DEFINES_SVH
`define APW_DEFINES_SVH

// Register offsets within the 8-byte host window
`define APW_OFS_STATUS_A 3'h0
`define APW_OFS_STATUS_B 3'h1
`define APW_OFS_DRIVE_OUT 3'h2
`define APW_OFS_RATE_MAIN 3'h4
`define APW_OFS_DATA 3'h5
`define APW_OFS_INPUT_CFG 3'h7

// Field positions
`define APW_DOR_NRESET_BIT 2
`define APW_DOR_MOTOR_MSB 7
`define APW_DOR_MOTOR_LSB 4
`define APW_DSR_SWRESET_BIT 7
`define APW_DSR_PDOWN_BIT 6

// Reset values
`define APW_DOR_RESET 8'h04
`define APW_DSR_RESET 8'h02
`define APW_CCR_RESET 8'h00
`define APW_MSR_IDLE 8'h80
`define APW_BUS_SYNC_RST 16'h1800

// Timing
`define APW_CLK_KHZ 20000
`define APW_PD_TIME_MS 10
`define APW_PD_CYCLES (`APW_PD_TIME_MS * `APW_CLK_KHZ)
`define APW_CNT_W 18
`define APW_RST_SEQ_LAST 8'h0F

`endif

// ==== core/apw_pkg.sv ====
// Types shared by the auto powerdown block.
// Assumes nothing beyond a SystemVerilog compiler.
package apw_pkg;
   typedef enum logic [1:0] {
      apw_reset,
      apw_run,
      apw_auto_pd,
      apw_direct_pd
   } apw_state_type;
endpackage

// ==== core/apw_sync.sv ====
// Two flip-flop synchroniser for a bundle of pin inputs.
// Assumes each bit is sampled independently; reset value is a parameter.
module apw_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Raw and synchronised bits
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   genvar i;
   for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            meta[i] <= RST_VAL[i];
            q[i] <= RST_VAL[i];
         end else begin
            meta[i] <= d[i];
            q[i] <= meta[i];
         end
      end
   end
endmodule

// ==== core/apw_wake.sv ====
// Standby-domain wake event latch for keyboard clock and infrared receive.
// Assumes standby_rstn comes from the standby supply power-on reset only.
module apw_wake (
   // Clock and standby reset
   input wire logic mclk,
   input wire logic standby_rstn,
   // Wake pins
   input wire logic keyboard_clock_pin,
   input wire logic infrared_receive_pin,
   // Wake configuration and clear
   input wire logic wake_mask_wr,
   input wire logic [1:0] wake_mask_data,
   input wire logic wake_clear,
   // Wake output, active low
   output logic wake_event_out_n
);
   logic [1:0] pin_s;
   logic [1:0] pin_d;
   logic [1:0] wake_mask;
   logic [1:0] fell;

   // Synchroniser and latch live on standby power, not the main reset
   apw_sync #(.W(2), .RST_VAL(2'h3)) u_pins (
      .clk(mclk),
      .rst_n(standby_rstn),
      .d({infrared_receive_pin, keyboard_clock_pin}),
      .q(pin_s)
   );

   assign fell = pin_d & ~pin_s & wake_mask;

   always_ff @(posedge mclk or negedge standby_rstn) begin
      if (!standby_rstn) begin
         pin_d <= 2'h3;
      end else begin
         pin_d <= pin_s;
      end
   end

   always_ff @(posedge mclk or negedge standby_rstn) begin
      if (!standby_rstn) begin
         wake_mask <= 2'h0;
      end else if (wake_mask_wr) begin
         wake_mask <= wake_mask_data; // see (R13)
      end
   end

   // Set wins over clear so an edge in the clear cycle is kept
   always_ff @(posedge mclk or negedge standby_rstn) begin
      if (!standby_rstn) begin
         wake_event_out_n <= 1'b1;
      end else if (|fell) begin
         wake_event_out_n <= 1'b0; // see (R12)
      end else if (wake_clear) begin
         wake_event_out_n <= 1'b1;
      end
   end

   chk_wake_edge: assert property (@(posedge mclk) disable iff (!standby_rstn)
      (|fell) |=> !wake_event_out_n) // see (R12)
      else $error("wake edge did not raise wake output");
   chk_wake_mask: assert property (@(posedge mclk) disable iff (!standby_rstn)
      wake_mask_wr |=> wake_mask == $past(wake_mask_data)) // see (R13)
      else $error("wake mask not stored");
endmodule

// ==== core/apw_top.sv ====
// Auto powerdown wake control for the floppy controller host interface.
// Assumes host pins are asynchronous and core status inputs run on mclk.
// Function
// (R1) Hardware or software reset wakes and runs the full reset sequence.
// (R2) A waking register access resumes with all state preserved.
// (R3) Motor enable set in drive output wakes; reading it never wakes.
// (R4) Any read of main status wakes the controller.
// (R5) Any read or write of the data register wakes the controller.
// (R6) After waking, the 10 ms powerdown timer restarts from zero.
// (R7) Status, drive output, rate and config accesses served without waking.
// (R8) Writes during powerdown are stored and take effect after waking.
// (R9) A non-waking access activates logic only while it lasts.
// (R10) Drive output or rate writes sleep unless motor or reset bits set.
// (R11) With supply not good, host reads and writes are not decoded.
// (R12) Wake pins stay functional without supply good on standby power.
// (R13) Wake configuration is reset only by the standby power-on reset.
// (R14) PLL off bit powers PLL down; all-clear with supply good selects it.
// (R15) In powerdown, interrupt and DMA request outputs are held low.
// (R16) In powerdown the drive interface is disabled.
// (R17) Enter powerdown only when motors off, idle, unloaded and timer done.
// (R18) Clearing auto powerdown enable cancels timer and keeps it awake.
// (R19) Direct powerdown overrides; after waking from it auto mode resumes.
// (R20) Wake is decoded from strobe and address in the access cycle.
`include "apw_defines.svh"

module apw_top #(
   parameter int unsigned PD_CYCLES = `APW_PD_CYCLES
) (
   // Clock and resets
   input wire logic mclk,
   input wire logic rstn,
   input wire logic standby_rstn,
   // Host bus pins
   input wire logic supply_ok,
   input wire logic reset_drv,
   input wire logic host_cs,
   input wire logic host_rd_n,
   input wire logic host_wr_n,
   input wire logic [2:0] host_addr,
   input wire logic [7:0] host_din,
   output logic [7:0] host_dout,
   output logic host_dout_oe,
   // Core status and requests
   input wire logic [7:0] status_a_in,
   input wire logic [7:0] status_b_in,
   input wire logic [7:0] input_status_in,
   input wire logic [7:0] main_status_in,
   input wire logic [7:0] core_rdata,
   input wire logic core_int,
   input wire logic core_drq,
   input wire logic head_unload_done,
   // Configuration bits
   input wire logic auto_pd_en,
   input wire logic pll_off_bit,
   input wire logic wake_power_bit,
   // Core and drive side controls
   output logic core_reset,
   output logic core_rd_pulse,
   output logic core_wr_pulse,
   output logic [7:0] core_wdata,
   output logic irq_out,
   output logic dma_request_out,
   output logic drive_enable,
   output logic [3:0] motor_out,
   output logic [1:0] rate_out,
   output logic logic_active,
   output logic pll_on,
   output apw_pkg::apw_state_type pd_state,
   // Standby wake interface
   input wire logic keyboard_clock_pin,
   input wire logic infrared_receive_pin,
   input wire logic wake_mask_wr,
   input wire logic [1:0] wake_mask_data,
   input wire logic wake_clear,
   output logic wake_event_out_n
);
   import apw_pkg::*;

   localparam logic [`APW_CNT_W-1:0] PD_LAST = `APW_CNT_W'(PD_CYCLES - 1);

   logic [15:0] bus_s;
   logic ok_s, hw_rst_s, cs_s, rd_n_s, wr_n_s;
   logic [2:0] addr_s;
   logic [7:0] din_s;
   logic rd_n_d, wr_n_d;
   logic rd_take, wr_take;
   logic motor_set, dor_reset, dsr_reset, dsr_pd, msr_rd, data_acc;
   logic wake_access, soft_reset, idle_ok, pd_timeout, bus_busy, awake;
   logic [7:0] drive_output_reg, dsr, config_control_reg;
   logic [`APW_CNT_W-1:0] pd_cnt;
   logic [7:0] rst_cnt;
   apw_state_type next_state;

   apw_sync #(.W(16), .RST_VAL(`APW_BUS_SYNC_RST)) u_bus (
      .clk(mclk),
      .rst_n(rstn),
      .d({supply_ok, reset_drv, host_cs, host_rd_n, host_wr_n, host_addr,
          host_din}),
      .q(bus_s)
   );

   assign {ok_s, hw_rst_s, cs_s, rd_n_s, wr_n_s, addr_s, din_s} = bus_s;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rd_n_d <= 1'b1;
         wr_n_d <= 1'b1;
      end else begin
         rd_n_d <= rd_n_s;
         wr_n_d <= wr_n_s;
      end
   end

   // Accesses are taken on the strobe's falling edge, gated by supply
   assign rd_take = ok_s && cs_s && !rd_n_s && rd_n_d; // see (R11)
   assign wr_take = ok_s && cs_s && !wr_n_s && wr_n_d; // see (R11)
   assign bus_busy = ok_s && cs_s && (!rd_n_s || !wr_n_s);

   // Wake decode sits in the take cycle so the state is valid early
   assign motor_set = wr_take && addr_s == `APW_OFS_DRIVE_OUT
      && |din_s[`APW_DOR_MOTOR_MSB:`APW_DOR_MOTOR_LSB]; // see (R3) see (R20)
   assign dor_reset = wr_take && addr_s == `APW_OFS_DRIVE_OUT
      && !din_s[`APW_DOR_NRESET_BIT]; // see (R10)
   assign dsr_reset = wr_take && addr_s == `APW_OFS_RATE_MAIN
      && din_s[`APW_DSR_SWRESET_BIT]; // see (R10)
   assign dsr_pd = wr_take && addr_s == `APW_OFS_RATE_MAIN
      && din_s[`APW_DSR_PDOWN_BIT] && !din_s[`APW_DSR_SWRESET_BIT];
   assign msr_rd = rd_take && addr_s == `APW_OFS_RATE_MAIN; // see (R4)
   assign data_acc = (rd_take || wr_take) && addr_s == `APW_OFS_DATA; // see (R5)
   assign wake_access = motor_set || msr_rd || data_acc; // see (R20)
   assign soft_reset = dor_reset || dsr_reset;

   assign pd_timeout = pd_cnt == PD_LAST;
   assign idle_ok = drive_output_reg[`APW_DOR_MOTOR_MSB:`APW_DOR_MOTOR_LSB] == 4'h0
      && main_status_in == `APW_MSR_IDLE && !core_int
      && head_unload_done && pd_timeout; // see (R17)
   assign awake = pd_state == apw_run || pd_state == apw_reset;

   always_comb begin
      next_state = pd_state;
      if (hw_rst_s || soft_reset) begin
         next_state = apw_reset; // see (R1)
      end else begin
         case (pd_state)
            apw_reset: begin
               if (rst_cnt == `APW_RST_SEQ_LAST) begin
                  next_state = apw_run;
               end
            end
            apw_run: begin
               if (dsr_pd) begin
                  next_state = apw_direct_pd;
               end else if (auto_pd_en && idle_ok && !wake_access) begin
                  next_state = apw_auto_pd; // see (R17)
               end
            end
            apw_auto_pd: begin
               if (dsr_pd) begin
                  next_state = apw_direct_pd; // see (R19)
               end else if (wake_access || !auto_pd_en) begin
                  next_state = apw_run; // see (R2) see (R18)
               end
            end
            apw_direct_pd: begin
               // Only a reset leaves direct powerdown, then auto mode resumes
               next_state = apw_direct_pd; // see (R19)
            end
            default: begin
               next_state = apw_reset;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pd_state <= apw_reset;
      end else begin
         pd_state <= next_state;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rst_cnt <= 8'h00;
      end else if (pd_state != apw_reset || hw_rst_s || soft_reset) begin
         rst_cnt <= 8'h00; // see (R1)
      end else if (rst_cnt != `APW_RST_SEQ_LAST) begin
         rst_cnt <= rst_cnt + 8'h01;
      end
   end

   // Timer only runs while awake and enabled, so a wake restarts it
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pd_cnt <= '0;
      end else if (pd_state != apw_run || !auto_pd_en) begin
         pd_cnt <= '0; // see (R6) see (R18)
      end else if (!pd_timeout) begin
         pd_cnt <= pd_cnt + 1'b1;
      end
   end

   // Writable registers keep their value in any state
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         drive_output_reg <= `APW_DOR_RESET;
         dsr <= `APW_DSR_RESET;
         config_control_reg <= `APW_CCR_RESET;
      end else if (hw_rst_s) begin
         drive_output_reg <= `APW_DOR_RESET;
         dsr <= `APW_DSR_RESET;
         config_control_reg <= `APW_CCR_RESET;
      end else if (wr_take) begin
         if (addr_s == `APW_OFS_DRIVE_OUT) begin
            drive_output_reg <= din_s; // see (R8)
         end else if (addr_s == `APW_OFS_RATE_MAIN) begin
            dsr <= din_s; // see (R8)
         end else if (addr_s == `APW_OFS_INPUT_CFG) begin
            config_control_reg <= din_s; // see (R8)
         end
      end
   end

   // Stored values reach the drive side only while awake
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         motor_out <= 4'h0;
         drive_enable <= 1'b0;
         rate_out <= 2'h0;
      end else begin
         drive_enable <= awake; // see (R16)
         motor_out <= awake ? drive_output_reg[`APW_DOR_MOTOR_MSB:`APW_DOR_MOTOR_LSB]
            : 4'h0; // see (R16)
         if (awake) begin
            rate_out <= config_control_reg[1:0]; // see (R8)
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         irq_out <= 1'b0;
         dma_request_out <= 1'b0;
         core_reset <= 1'b1;
      end else begin
         irq_out <= awake && core_int; // see (R15)
         dma_request_out <= awake && core_drq; // see (R15)
         core_reset <= next_state == apw_reset; // see (R1)
      end
   end

   // Data register strobes are registered from the take and appear in the same cycle that the wake takes effect
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         core_rd_pulse <= 1'b0;
         core_wr_pulse <= 1'b0;
         core_wdata <= 8'h00;
      end else begin
         core_rd_pulse <= rd_take && addr_s == `APW_OFS_DATA; // see (R5)
         core_wr_pulse <= wr_take && addr_s == `APW_OFS_DATA; // see (R5)
         if (wr_take) begin
            core_wdata <= din_s;
         end
      end
   end

   // Reads show live status in every state
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         host_dout <= 8'h00;
         host_dout_oe <= 1'b0;
      end else begin
         host_dout_oe <= ok_s && cs_s && !rd_n_s
            && addr_s != 3'h3 && addr_s != 3'h6; // see (R11)
         if (addr_s == `APW_OFS_STATUS_A) begin
            host_dout <= status_a_in; // see (R7)
         end else if (addr_s == `APW_OFS_STATUS_B) begin
            host_dout <= status_b_in; // see (R7)
         end else if (addr_s == `APW_OFS_DRIVE_OUT) begin
            host_dout <= drive_output_reg; // see (R7)
         end else if (addr_s == `APW_OFS_RATE_MAIN) begin
            host_dout <= main_status_in;
         end else if (addr_s == `APW_OFS_DATA) begin
            host_dout <= core_rdata;
         end else if (addr_s == `APW_OFS_INPUT_CFG) begin
            host_dout <= input_status_in; // see (R7)
         end else begin
            host_dout <= 8'h00;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         logic_active <= 1'b1;
         pll_on <= 1'b0;
      end else begin
         logic_active <= awake || bus_busy; // see (R9)
         pll_on <= !pll_off_bit && !wake_power_bit && ok_s; // see (R14)
      end
   end

   apw_wake u_wake (
      .mclk(mclk),
      .standby_rstn(standby_rstn),
      .keyboard_clock_pin(keyboard_clock_pin),
      .infrared_receive_pin(infrared_receive_pin),
      .wake_mask_wr(wake_mask_wr),
      .wake_mask_data(wake_mask_data),
      .wake_clear(wake_clear),
      .wake_event_out_n(wake_event_out_n)
   );

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   chk_reset_wakes: assert property ((soft_reset || hw_rst_s)
      |=> pd_state == apw_reset ##1 core_reset) // see (R1)
      else $error("reset did not start reset sequence");
   chk_wake_preserve: assert property (pd_state == apw_auto_pd && msr_rd
      |=> $stable(drive_output_reg) && $stable(config_control_reg)) // see (R2)
      else $error("state lost on wake");
   chk_motor_wake: assert property (pd_state == apw_auto_pd && motor_set
      && !hw_rst_s && !soft_reset |=> pd_state == apw_run) // see (R3)
      else $error("motor enable write did not wake");
   chk_msr_wake: assert property (pd_state == apw_auto_pd && msr_rd
      && !hw_rst_s |=> pd_state == apw_run) // see (R4)
      else $error("main status read did not wake");
   chk_data_wake: assert property (pd_state == apw_auto_pd && data_acc
      && !hw_rst_s && !soft_reset |=> pd_state == apw_run ##0 core_rd_pulse
      || core_wr_pulse) // see (R5)
      else $error("data access did not wake");
   chk_timer_restart: assert property (pd_state == apw_auto_pd
      ##1 pd_state == apw_run && auto_pd_en
      |-> pd_cnt == '0 ##1 pd_cnt == 1) // see (R6)
      else $error("powerdown timer not restarted");
   chk_quiet_access: assert property (pd_state == apw_auto_pd && auto_pd_en
      && !hw_rst_s && (rd_take || wr_take) && !wake_access && !soft_reset
      && !dsr_pd |=> pd_state == apw_auto_pd) // see (R7) see (R10)
      else $error("non-waking access woke the part");
   chk_write_kept: assert property (pd_state == apw_auto_pd && wr_take
      && addr_s == `APW_OFS_INPUT_CFG && !hw_rst_s
      |=> config_control_reg == $past(din_s) ##1 pd_state != apw_run || rate_out == config_control_reg[1:0])
      // see (R8)
      else $error("write during powerdown not kept");
   chk_active_ends: assert property (pd_state == apw_auto_pd && !bus_busy
      ##1 pd_state == apw_auto_pd && !bus_busy
      |=> !logic_active) // see (R9)
      else $error("logic left active after access");
   chk_no_decode: assert property (!ok_s |=> !core_rd_pulse
      && !core_wr_pulse && !host_dout_oe) // see (R11)
      else $error("bus decoded without supply good");
   chk_pll_select: assert property (##1 pll_on == ($past(!pll_off_bit)
      && $past(!wake_power_bit) && $past(ok_s))) // see (R14)
      else $error("pll power wrong");
   chk_outputs_low: assert property (pd_state == apw_auto_pd
      |=> !irq_out && !dma_request_out) // see (R15)
      else $error("request output active in powerdown");
   chk_drive_off: assert property (pd_state == apw_auto_pd
      |=> !drive_enable && motor_out == 4'h0) // see (R16)
      else $error("drive side active in powerdown");
   chk_enter_cond: assert property (pd_state == apw_run
      ##1 pd_state == apw_auto_pd |-> $past(idle_ok)) // see (R17)
      else $error("powerdown entered early");
   chk_disable_hold: assert property (!auto_pd_en
      |=> pd_state != apw_auto_pd) // see (R18)
      else $error("powerdown while disabled");
   chk_direct_exit: assert property (pd_state == apw_direct_pd && dsr_reset
      |=> pd_state == apw_reset) // see (R19)
      else $error("direct powerdown not left by reset");

   cov_auto_pd: cover property (pd_state == apw_run ##1 pd_state == apw_auto_pd);
   cov_msr_wake: cover property (pd_state == apw_auto_pd && msr_rd);
   cov_quiet_wr: cover property (pd_state == apw_auto_pd && wr_take
      && addr_s == `APW_OFS_INPUT_CFG);
   cov_direct: cover property (pd_state == apw_direct_pd);
endmodule

// ==== tb/apw_host_model.sv ====
// Host processor model: byte reads and writes on the block's I/O window.
// Assumes the bench calls cycle() from one process at a time.
module apw_host_model (
   // Clock
   input wire logic mclk,
   // Host bus pins
   output logic host_cs,
   output logic host_rd_n,
   output logic host_wr_n,
   output logic [2:0] host_addr,
   output logic [7:0] host_din
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      host_cs = 1'b0;
      host_rd_n = 1'b1;
      host_wr_n = 1'b1;
      host_addr = 3'h0;
      host_din = 8'h00;
   end
   // Strobe outlasts the two-flop take and the answer; no ready exists
   task automatic cycle(input logic rd, input logic [2:0] a,
                        input logic [7:0] d);
      @(posedge mclk);
      host_cs <= 1'b1;
      host_addr <= a;
      host_din <= d;
      host_rd_n <= !rd;
      host_wr_n <= rd;
      repeat (6) @(posedge mclk);
      host_cs <= 1'b0;
      host_rd_n <= 1'b1;
      host_wr_n <= 1'b1;
      // Released data lines show no stale byte
      host_din <= ~d;
      repeat (5) @(posedge mclk);
   endtask
endmodule

// ==== tb/fdc_auto_powerdown_wake_test.sv ====
// Self-checking bench for the auto powerdown wake block.
// Assumes the host model drives the bus; the timer is shortened to 50.
`include "apw_defines.svh"
module fdc_auto_powerdown_wake_test;
   timeunit 1ns;
   timeprecision 1ps;
   import apw_pkg::*;
   logic mclk, rstn, standby_rstn, supply_ok, reset_drv, oe_q;
   logic host_cs, host_rd_n, host_wr_n, host_dout_oe, core_reset;
   logic [2:0] host_addr;
   logic [7:0] host_din, host_dout, core_wdata, core_rdata;
   logic [7:0] status_a_in, status_b_in, input_status_in, main_status_in;
   logic core_int, core_drq, head_unload_done, auto_pd_en, pll_off_bit;
   logic wake_power_bit, keyboard_clock_pin, infrared_receive_pin;
   logic wake_mask_wr, wake_clear, core_rd_pulse, core_wr_pulse, irq_out;
   logic dma_request_out, drive_enable, logic_active, pll_on;
   logic wake_event_out_n;
   logic [1:0] wake_mask_data, rate_out;
   logic [3:0] motor_out;
   apw_state_type pd_state;
   logic [7:0] exp_q[$];
   int n_mismatch, check_count, seed, i;

   apw_host_model host (.mclk(mclk), .host_cs(host_cs),
      .host_rd_n(host_rd_n), .host_wr_n(host_wr_n),
      .host_addr(host_addr), .host_din(host_din));
   apw_top #(.PD_CYCLES(50)) uut (.mclk(mclk), .rstn(rstn),
      .standby_rstn(standby_rstn), .supply_ok(supply_ok),
      .reset_drv(reset_drv), .host_cs(host_cs), .host_rd_n(host_rd_n),
      .host_wr_n(host_wr_n), .host_addr(host_addr), .host_din(host_din),
      .host_dout(host_dout), .host_dout_oe(host_dout_oe),
      .status_a_in(status_a_in), .status_b_in(status_b_in),
      .input_status_in(input_status_in), .main_status_in(main_status_in),
      .core_rdata(core_rdata), .core_int(core_int), .core_drq(core_drq),
      .head_unload_done(head_unload_done), .auto_pd_en(auto_pd_en),
      .pll_off_bit(pll_off_bit), .wake_power_bit(wake_power_bit),
      .core_reset(core_reset), .core_rd_pulse(core_rd_pulse),
      .core_wr_pulse(core_wr_pulse), .core_wdata(core_wdata),
      .irq_out(irq_out), .dma_request_out(dma_request_out),
      .drive_enable(drive_enable), .motor_out(motor_out),
      .rate_out(rate_out), .logic_active(logic_active), .pll_on(pll_on),
      .pd_state(pd_state), .keyboard_clock_pin(keyboard_clock_pin),
      .infrared_receive_pin(infrared_receive_pin),
      .wake_mask_wr(wake_mask_wr), .wake_mask_data(wake_mask_data),
      .wake_clear(wake_clear), .wake_event_out_n(wake_event_out_n));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   task automatic chk(input string nm, input logic [7:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.cycle(1'b1, a, 8'h00);
   endtask
   task automatic st(input apw_state_type s);
      chk("pd_state", 8'(pd_state), 8'(s));
   endtask
   // Bounded wait; an exhausted bound ends the run
   task automatic wait_st(input apw_state_type s, input int lim);
      int k;
      k = 0;
      while (pd_state !== s && k < lim) begin
         @(posedge mclk);
         #1;
         k++;
      end
      st(s);
      if (k == lim)
         results();
   endtask
   task automatic fin(input string nm);
      $display("test %s done", nm);
   endtask

   // Each rising read enable is one answer, matched oldest first
   always @(negedge mclk) begin
      if (host_dout_oe === 1'b1 && oe_q !== 1'b1) begin
         if (exp_q.size() == 0)
            chk("unexpected read", 8'h00, 8'hFF);
         else
            chk("host_dout", host_dout, exp_q.pop_front());
      end
      oe_q = host_dout_oe;
   end

   initial begin
      seed = 2;
      {rstn, standby_rstn, reset_drv, core_int, core_drq} = '0;
      {pll_off_bit, wake_power_bit, wake_mask_wr, wake_clear} = '0;
      {supply_ok, head_unload_done, auto_pd_en} = 3'h7;
      {keyboard_clock_pin, infrared_receive_pin} = 2'h3;
      wake_mask_data = 2'h0;
      main_status_in = `APW_MSR_IDLE;
      {status_a_in, status_b_in, input_status_in} = '0;
      core_rdata = 8'h3C;
      oe_q = 1'b0;
      repeat (16) @(posedge mclk);
      rstn <= 1'b1;
      standby_rstn <= 1'b1;
      wait_st(apw_run, 40);
      wait_st(apw_auto_pd, 200);
      @(posedge mclk);
      core_drq <= 1'b1;
      repeat (4) @(posedge mclk);
      chk("dma_request_out", 8'(dma_request_out), 8'h00);
      chk("drive_enable", 8'(drive_enable), 8'h00);
      core_drq <= 1'b0;
      status_a_in <= $random(seed);
      status_b_in <= $random(seed);
      input_status_in <= $random(seed);
      core_rdata <= $random(seed);
      @(posedge mclk);
      rd(`APW_OFS_STATUS_A, status_a_in);
      rd(`APW_OFS_STATUS_B, status_b_in);
      rd(`APW_OFS_INPUT_CFG, input_status_in);
      host.cycle(1'b0, `APW_OFS_DRIVE_OUT, 8'h0C);
      rd(`APW_OFS_DRIVE_OUT, 8'h0C);
      host.cycle(1'b0, `APW_OFS_INPUT_CFG, 8'h03);
      host.cycle(1'b0, `APW_OFS_RATE_MAIN, `APW_DSR_RESET);
      st(apw_auto_pd);
      chk("logic_active", 8'(logic_active), 8'h00);
      chk("rate_out", 8'(rate_out), 8'h00);
      fin("quiet access");
      rd(`APW_OFS_RATE_MAIN, `APW_MSR_IDLE);
      st(apw_run);
      chk("rate_out", 8'(rate_out), 8'h03);
      rd(`APW_OFS_DRIVE_OUT, 8'h0C);
      // Timer of 50 restarted at the wake; look well before it runs out
      repeat (20) @(posedge mclk);
      st(apw_run);
      wait_st(apw_auto_pd, 40);
      fin("status wake");
      host.cycle(1'b0, `APW_OFS_DATA, 8'hA5);
      st(apw_run);
      chk("core_wdata", core_wdata, 8'hA5);
      wait_st(apw_auto_pd, 100);
      rd(`APW_OFS_DATA, core_rdata);
      st(apw_run);
      wait_st(apw_auto_pd, 100);
      host.cycle(1'b0, `APW_OFS_DRIVE_OUT, 8'h1C);
      st(apw_run);
      chk("motor_out", 8'(motor_out), 8'h01);
      host.cycle(1'b0, `APW_OFS_DRIVE_OUT, 8'h0C);
      wait_st(apw_auto_pd, 100);
      fin("data and motor wake");
      supply_ok <= 1'b0;
      wake_mask_wr <= 1'b1;
      wake_mask_data <= 2'h1;
      @(posedge mclk);
      wake_mask_wr <= 1'b0;
      host.cycle(1'b1, `APW_OFS_RATE_MAIN, 8'h00);
      host.cycle(1'b0, `APW_OFS_DRIVE_OUT, 8'h1C);
      st(apw_auto_pd);
      infrared_receive_pin <= 1'b0;
      keyboard_clock_pin <= 1'b0;
      repeat (6) @(posedge mclk);
      chk("wake_event_out_n", 8'(wake_event_out_n), 8'h00);
      wake_clear <= 1'b1;
      {keyboard_clock_pin, infrared_receive_pin} <= 2'h3;
      @(posedge mclk);
      wake_clear <= 1'b0;
      infrared_receive_pin <= 1'b0;
      repeat (6) @(posedge mclk);
      chk("wake_event_out_n", 8'(wake_event_out_n), 8'h01);
      fin("supply low");
      // Only off=0, wake power=0, supply good=1 may power the PLL
      for (i = 0; i < 8; i++) begin
         {pll_off_bit, wake_power_bit, supply_ok} <= 3'(i);
         repeat (5) @(posedge mclk);
         chk("pll_on", 8'(pll_on), 8'(i == 1));
      end
      {pll_off_bit, wake_power_bit, supply_ok} <= 3'h1;
      auto_pd_en <= 1'b0;
      wait_st(apw_run, 20);
      repeat (80) @(posedge mclk);
      st(apw_run);
      auto_pd_en <= 1'b1;
      wait_st(apw_auto_pd, 100);
      host.cycle(1'b0, `APW_OFS_RATE_MAIN, 8'h42);
      st(apw_direct_pd);
      host.cycle(1'b0, `APW_OFS_RATE_MAIN, 8'h82);
      st(apw_reset);
      wait_st(apw_run, 40);
      wait_st(apw_auto_pd, 100);
      reset_drv <= 1'b1;
      repeat (5) @(posedge mclk);
      st(apw_reset);
      reset_drv <= 1'b0;
      wait_st(apw_run, 40);
      rd(`APW_OFS_DRIVE_OUT, `APW_DOR_RESET);
      fin("resets and pll");
      results();
   end
endmodule
